// ==== hdl/input_port_change_interrupt.sv ====
// Eight-bit input port with per-group change interrupts and register port
//
// Chosen here: the strobed register port.
`timescale 1ns/1ns

// What this block does
// R1: Pin data reads 1 high, 0 low
// R2: Pin data registers read-only, writes ignored
// R3: Only selected pins join interrupt condition
// R4: Compare bit 1 falling, 0 rising edge
// R5: Compare only selected pins of each group
// R6: Match to mismatch establishes group condition
// R7: Mismatch to other mismatch raises nothing
// R8: Per-group one-bit interrupt enable mask
// R9: Pending flag sets regardless of mask
// R10: Masked group never requests CPU interrupt
// R11: Write one clears flag, zero keeps
// R12: Flag zero for group0, one group1
// R13: Set flag keeps requesting interrupt again
// R14: Software clears flag before re-enabling interrupts
// R15: Top pin also feeds timer clock
// R16: Reset clears flags, selects and masks
// R17: Unused mask/flag bits read zero
// R18: Pins pass two flip-flops before use
module input_port_change_interrupt
  import kport_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [3:0] group0_input_pins,
  input wire logic [3:0] group1_input_pins,
  input wire logic [15:0] bus_addr,
  input wire logic [3:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [3:0] bus_rdata,
  output logic irq,
  output logic timer_ext_clock
);

  typedef struct packed {
    logic [1:0][3:0] pin_interrupt_select;
    logic [1:0][3:0] edge_compare_bits;
    logic [1:0] interrupt_enable;
    logic [1:0] interrupt_pending;
    logic [1:0] mismatch_prev;
    logic [3:0] rdata;
    logic irq;
    logic timer_clk;
  } port_state_s;

  localparam port_state_s STATE_RST = '{
    pin_interrupt_select: {SELECT_RST, SELECT_RST},
    edge_compare_bits: {EXPECTED_RST, EXPECTED_RST},
    interrupt_enable: {ENABLE_RST, ENABLE_RST},
    interrupt_pending: {PENDING_RST, PENDING_RST},
    mismatch_prev: 2'b00,
    rdata: RDATA_IDLE,
    irq: 1'b0,
    timer_clk: 1'b0
  };

  port_state_s st_reg;
  port_state_s st_next;

  pin_level_if pin_bus ();

  logic [1:0][3:0] group_levels;
  logic [1:0] mismatch_now;
  logic [1:0] change_event;

  // ==========================================================================
  // Pin synchronisation
  // Raw pins are asynchronous to mclk; only the synchronised copy is used
  pin_sync u_pin_sync ( // R18
    .mclk(mclk),
    .rstn(rstn),
    .pins_async({group1_input_pins, group0_input_pins}),
    .sync_out(pin_bus.producer)
  );

  assign group_levels[0] = pin_bus.levels[3:0];
  assign group_levels[1] = pin_bus.levels[7:4];

  // ==========================================================================
  // Change detection per group
  genvar g;
  generate
    for (g = 0; g < GROUPS; g++) begin : g_group
      // A compare bit of 1 expects a high level, so the pin falling breaks the
      // match; a bit of 0 expects low, so the pin rising breaks it
      assign mismatch_now[g] =
        |(st_reg.pin_interrupt_select[g] & (group_levels[g] ^ st_reg.edge_compare_bits[g])); // R3 R4 R5
      // Only the step from full match to mismatch counts, so moving between
      // two mismatching patterns stays silent
      assign change_event[g] = mismatch_now[g] & ~st_reg.mismatch_prev[g]; // R6 R7
    end
  endgenerate

  // ==========================================================================
  // Register access and interrupt state
  always_comb begin
    st_next = st_reg;
    st_next.mismatch_prev = mismatch_now;
    st_next.timer_clk = pin_bus.levels[GROUP_W + TIMER_PIN_BIT]; // R15

    // Writes; the pin level addresses take no write at all
    if (bus_wr) begin
      case (bus_addr)
        GROUP0_INTERRUPT_SELECT_OFS: begin
          st_next.pin_interrupt_select[0] = bus_wdata;
        end
        GROUP1_INTERRUPT_SELECT_OFS: begin
          st_next.pin_interrupt_select[1] = bus_wdata;
        end
        GROUP0_EXPECTED_LEVELS_OFS: begin
          st_next.edge_compare_bits[0] = bus_wdata;
        end
        GROUP1_EXPECTED_LEVELS_OFS: begin
          st_next.edge_compare_bits[1] = bus_wdata;
        end
        GROUP0_INTERRUPT_MASK_OFS: begin
          st_next.interrupt_enable[0] = bus_wdata[ENABLE_BIT]; // R8 R17
        end
        GROUP1_INTERRUPT_MASK_OFS: begin
          st_next.interrupt_enable[1] = bus_wdata[ENABLE_BIT]; // R8 R17
        end
        GROUP0_INTERRUPT_FLAG_OFS: begin
          if (bus_wdata[PENDING_BIT]) begin
            st_next.interrupt_pending[0] = 1'b0; // R11
          end
        end
        GROUP1_INTERRUPT_FLAG_OFS: begin
          if (bus_wdata[PENDING_BIT]) begin
            st_next.interrupt_pending[1] = 1'b0; // R11
          end
        end
        default: begin
          st_next.rdata = st_next.rdata; // R2
        end
      endcase
    end

    // Events are applied after the clear so a same-cycle event is never lost
    for (int i = 0; i < GROUPS; i++) begin
      if (change_event[i]) begin
        st_next.interrupt_pending[i] = 1'b1; // R9 R12
      end
    end

    // Read data stand only in the cycle after the strobe
    st_next.rdata = RDATA_IDLE;
    if (bus_rd) begin
      case (bus_addr)
        GROUP0_INTERRUPT_SELECT_OFS: st_next.rdata = st_reg.pin_interrupt_select[0];
        GROUP1_INTERRUPT_SELECT_OFS: st_next.rdata = st_reg.pin_interrupt_select[1];
        GROUP0_PIN_LEVELS_OFS: st_next.rdata = group_levels[0]; // R1
        GROUP1_PIN_LEVELS_OFS: st_next.rdata = group_levels[1]; // R1
        GROUP0_EXPECTED_LEVELS_OFS: st_next.rdata = st_reg.edge_compare_bits[0];
        GROUP1_EXPECTED_LEVELS_OFS: st_next.rdata = st_reg.edge_compare_bits[1];
        GROUP0_INTERRUPT_MASK_OFS: st_next.rdata = {3'b000, st_reg.interrupt_enable[0]}; // R17
        GROUP1_INTERRUPT_MASK_OFS: st_next.rdata = {3'b000, st_reg.interrupt_enable[1]}; // R17
        GROUP0_INTERRUPT_FLAG_OFS: st_next.rdata = {3'b000, st_reg.interrupt_pending[0]}; // R11 R17
        GROUP1_INTERRUPT_FLAG_OFS: st_next.rdata = {3'b000, st_reg.interrupt_pending[1]}; // R11 R17
        default: st_next.rdata = RDATA_IDLE;
      endcase
    end

    // Level request: the CPU sees it again after every re-enable until cleared
    st_next.irq = |(st_next.interrupt_pending & st_next.interrupt_enable); // R10 R13
  end

  // ==========================================================================
  // State register
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_reg <= STATE_RST; // R16
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus_rdata = st_reg.rdata;
  assign irq = st_reg.irq;
  assign timer_ext_clock = st_reg.timer_clk;

endmodule // input_port_change_interrupt

// ==== hdl/kport_pkg.sv ====
// Package: register map, field layout and reset values of the input port block
package kport_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 4;
  localparam int GROUP_W = 4;
  localparam int GROUPS = 2;
  localparam int PINS = GROUPS * GROUP_W;

  // ==========================================================================
  // Register offsets
  localparam logic [15:0] GROUP0_INTERRUPT_SELECT_OFS = 16'hff20;
  localparam logic [15:0] GROUP0_PIN_LEVELS_OFS = 16'hff21;
  localparam logic [15:0] GROUP0_EXPECTED_LEVELS_OFS = 16'hff22;
  localparam logic [15:0] GROUP1_INTERRUPT_SELECT_OFS = 16'hff24;
  localparam logic [15:0] GROUP1_PIN_LEVELS_OFS = 16'hff25;
  localparam logic [15:0] GROUP1_EXPECTED_LEVELS_OFS = 16'hff26;
  localparam logic [15:0] GROUP0_INTERRUPT_MASK_OFS = 16'hffe4;
  localparam logic [15:0] GROUP1_INTERRUPT_MASK_OFS = 16'hffe5;
  localparam logic [15:0] GROUP0_INTERRUPT_FLAG_OFS = 16'hfff4;
  localparam logic [15:0] GROUP1_INTERRUPT_FLAG_OFS = 16'hfff5;

  // ==========================================================================
  // Field positions
  localparam int ENABLE_BIT = 0;
  localparam int PENDING_BIT = 0;
  localparam int TIMER_PIN_BIT = 3;

  // ==========================================================================
  // Reset values
  localparam logic [3:0] SELECT_RST = 4'h0;
  localparam logic [3:0] EXPECTED_RST = 4'h0;
  localparam logic ENABLE_RST = 1'b0;
  localparam logic PENDING_RST = 1'b0;
  localparam logic [3:0] RDATA_IDLE = 4'h0;

endpackage

// ==== hdl/pin_level_if.sv ====
// Interface: synchronised pin levels passed from the synchroniser to the port logic
`timescale 1ns/1ns
interface pin_level_if;
  logic [7:0] levels;
  modport producer (output levels);
  modport consumer (input levels);
endinterface

// ==== hdl/pin_sync.sv ====
// Two-stage synchroniser for the eight input pins
`timescale 1ns/1ns
module pin_sync
  import kport_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] pins_async,
  pin_level_if.producer sync_out
);

  typedef struct packed {
    logic [7:0] stage1;
    logic [7:0] stage2;
  } sync_state_s;

  sync_state_s st_reg;
  sync_state_s st_next;

  // ==========================================================================
  // Next state
  // The first stage feeds only the second stage; nothing else looks at it
  always_comb begin
    st_next = st_reg;
    st_next.stage1 = pins_async;
    st_next.stage2 = st_reg.stage1;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out.levels = st_reg.stage2;

endmodule // pin_sync

// ==== test/kport_asserts.sv ====
// Checker: port-level properties of the input port block
`timescale 1ns/1ns
module kport_asserts (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [3:0] group0_input_pins,
  input wire logic [3:0] group1_input_pins,
  input wire logic [15:0] bus_addr,
  input wire logic [3:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [3:0] bus_rdata,
  input wire logic irq,
  input wire logic timer_ext_clock
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ==========================================================================
  // Read port, synchroniser, reset and interrupt masking
  a_pin_read0: assert property (bus_rd && bus_addr == 16'hff21 && $past(rstn, 2) && $past(rstn)
    |=> bus_rdata == $past(group0_input_pins, 3)) else $error("group0 pin read wrong");
  a_pin_read1: assert property (bus_rd && bus_addr == 16'hff25 && $past(rstn, 2) && $past(rstn)
    |=> bus_rdata == $past(group1_input_pins, 3)) else $error("group1 pin read wrong");
  a_timer_copy: assert property ($past(rstn, 3) && $past(rstn, 2) && $past(rstn)
    |-> timer_ext_clock == $past(group1_input_pins[3], 3)) else $error("timer clock copy wrong");
  a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 4'h0) else $error("stray read data");
  a_unused_bits: assert property ($past(bus_rd) && $past(bus_addr[15:5]) == 11'h7ff
    |-> bus_rdata[3:1] == 3'b000) else $error("unused bits not zero");
  a_unmapped_read: assert property ($past(bus_rd) && $past(bus_addr[15:8]) != 8'hff
    |-> bus_rdata == 4'h0) else $error("unmapped read not zero");
  a_reset_quiet: assert property (!$past(rstn)
    |-> !irq && bus_rdata == 4'h0 && !timer_ext_clock) else $error("outputs not cleared by reset");
  a_masked_off: assert property (bus_wr && bus_addr == 16'hffe4 && !bus_wdata[0] ##1
    bus_wr && bus_addr == 16'hffe5 && !bus_wdata[0] |=> !irq) else $error("irq while masked");
endmodule // kport_asserts

// ==== test/switch_bank.sv ====
// Partner model: switches driving the eight input pins
`timescale 1ns/1ns
module switch_bank (
  input wire logic mclk,
  input wire logic [3:0] cmd0,
  input wire logic [3:0] cmd1,
  output logic [3:0] pins0,
  output logic [3:0] pins1
);
  always @(posedge mclk) begin
    pins0 <= cmd0;
    pins1 <= cmd1;
  end
endmodule // switch_bank

// ==== test/input_port_change_interrupt_test.sv ====
// Testbench: random pin and register traffic against a behavioural model
`timescale 1ns/1ns
module input_port_change_interrupt_test;
  logic mclk = 0, rstn = 0, bus_wr = 0, bus_rd = 0, irq, tclk;
  logic [15:0] bus_addr = 16'h0000, a;
  logic [3:0] bus_wdata = 4'h0, bus_rdata, p0, p1, cmd[2] = '{4'h0, 4'h0};
  int fail_count = 0, total_checks = 0, cyc = 0, sel[2], cmp[2], en[2], flg[2], pm[2], pv[2], r, g, d;
  input_port_change_interrupt dut (.mclk, .rstn, .group0_input_pins(p0), .group1_input_pins(p1), .bus_addr,
    .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .irq, .timer_ext_clock(tclk));
  switch_bank sw (.mclk, .cmd0(cmd[0]), .cmd1(cmd[1]), .pins0(p0), .pins1(p1));
  initial forever #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  // ==========================================================================
  // Bus tasks
  task automatic chk(logic [3:0] seen, logic [3:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(logic [15:0] ad, int v);
    bus_wr <= 1'b1;
    bus_addr <= ad;
    bus_wdata <= 4'(v);
    @(posedge mclk);
    bus_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(logic [15:0] ad, int e);
    bus_rd <= 1'b1;
    bus_addr <= ad;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1 chk(bus_rdata, 4'(e));
    @(posedge mclk);
  endtask
  function automatic int mis(int k);
    return (sel[k] & (pv[k] ^ cmp[k])) != 0;
  endfunction
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    r = $urandom(32'h19af);
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    for (g = 0; g < 2; g++) begin
      rd(16'hff20 + 16'(4 * g), 0);
      rd(16'hff22 + 16'(4 * g), 0);
      rd(16'hffe4 + 16'(g), 0);
      rd(16'hfff4 + 16'(g), 0);
    end
    rd(16'h1234, 0);
    repeat (300) begin
      r = $urandom;
      g = r & 1;
      d = (r >> 4) & 15;
      a = 16'hff20 + 16'(4 * g);
      case ((r >> 8) % 6)
        0: begin
          cmd[g] <= 4'(d);
          pv[g] = d;
        end
        1: begin
          wr(a, d);
          sel[g] = d;
        end
        2: begin
          wr(a + 16'h0002, d);
          cmp[g] = d;
        end
        3: begin
          wr(16'hffe4 + 16'(g), d);
          en[g] = d & 1;
        end
        4: begin
          wr(16'hfff4 + 16'(g), d);
          if (d & 1) flg[g] = 0;
        end
        default: wr(a + 16'h0001, d);
      endcase
      repeat (6) @(posedge mclk);
      for (int k = 0; k < 2; k++) begin
        if (mis(k) && !pm[k]) flg[k] = 1;
        pm[k] = mis(k);
      end
      chk({3'b000, irq}, 4'((flg[0] & en[0]) | (flg[1] & en[1])));
      chk({3'b000, tclk}, 4'((pv[1] >> 3) & 1));
      rd(a, sel[g]);
      rd(a + 16'h0001, pv[g]);
      rd(a + 16'h0002, cmp[g]);
      rd(16'hffe4 + 16'(g), en[g]);
      rd(16'hfff4 + 16'(g), flg[g]);
    end
    // Reset in mid-run must drop the group1 select, mask and flag again
    rstn <= 1'b0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    chk({3'b000, irq}, 4'h0);
    rd(16'hff24, 0);
    rd(16'hffe5, 0);
    rd(16'hfff5, 0);
    wr(16'hff22, ~pv[0] & 15);
    wr(16'hff20, 0);
    wr(16'hff20, 15);
    wr(16'hffe4, 1);
    repeat (4) @(posedge mclk);
    chk({3'b000, irq}, 4'h1);
    bus_wr <= 1'b1;
    bus_addr <= 16'hffe4;
    bus_wdata <= 4'h0;
    @(posedge mclk);
    bus_addr <= 16'hffe5;
    @(posedge mclk);
    bus_wr <= 1'b0;
    @(posedge mclk);
    chk({3'b000, irq}, 4'h0);
    wr(16'hff20, 0);
    wr(16'hfff4, 1);
    rd(16'hfff4, 0);
    // Event and clear meet in one cycle: the set has to win
    bus_wr <= 1'b1;
    bus_addr <= 16'hff20;
    bus_wdata <= 4'hf;
    @(posedge mclk);
    bus_addr <= 16'hfff4;
    bus_wdata <= 4'h1;
    @(posedge mclk);
    bus_wr <= 1'b0;
    @(posedge mclk);
    rd(16'hfff4, 1);
    tally_and_finish();
  end
endmodule // input_port_change_interrupt_test
bind input_port_change_interrupt kport_asserts chk_i (.mclk, .rstn, .group0_input_pins, .group1_input_pins,
  .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .irq, .timer_ext_clock);
